// ===== design/mid_pkg.sv
/*
 * Constants for the instruction decode and cycle timing block:
 * word layout, field positions, opcode patterns and phase timing.
 * Assumes a 14-bit program word presented on the core clock.
 */
package mid_pkg;

    // ----------------------------------------------------------------
    // word and field layout
    // ----------------------------------------------------------------
    localparam int MID_INSTR_W = 14;
    localparam int MID_OPC_LSB = 8;
    localparam int MID_OPC_W = 6;
    localparam int MID_D_BIT = 7;
    localparam int MID_F_W = 7;
    localparam int MID_B_LSB = 7;
    localparam int MID_B_W = 3;
    localparam int MID_K8_W = 8;
    localparam int MID_K11_W = 11;
    localparam int MID_N_OFS_BIT = 6;
    localparam int MID_N_INC_BIT = 2;
    localparam int MID_MM_W = 2;
    localparam logic [6:0] MID_F_MAX = 7'h7F;
    localparam logic [5:0] MID_INDIRECT_FILE_REGISTER_HI = 6'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int MID_OSC_PER_CYCLE = 4;
    localparam logic [1:0] MID_PHASE_FIRST = 2'h0;
    localparam logic [1:0] MID_PHASE_PRELAST = 2'h2;

    // ----------------------------------------------------------------
    // opcode patterns, mask then match
    // ----------------------------------------------------------------
    localparam logic [13:0] MID_M_TOP2 = 14'h3000;
    localparam logic [13:0] MID_P_ABS = 14'h2000;
    localparam logic [13:0] MID_P_BITOP = 14'h1000;
    localparam logic [13:0] MID_M_BIT4 = 14'h3C00;
    localparam logic [13:0] MID_P_SKIP_CLR = 14'h1800;
    localparam logic [13:0] MID_P_SKIP_SET = 14'h1C00;
    localparam logic [13:0] MID_M_OP6 = 14'h3F00;
    localparam logic [13:0] MID_P_DEC_SKIP = 14'h0B00;
    localparam logic [13:0] MID_P_INC_SKIP = 14'h0F00;
    localparam logic [13:0] MID_P_RET_LIT = 14'h3400;
    localparam logic [13:0] MID_P_PTR_OFS = 14'h3F00;
    localparam logic [13:0] MID_M_BRA = 14'h3E00;
    localparam logic [13:0] MID_P_BRA = 14'h3200;
    localparam logic [13:0] MID_M_FULL = 14'h3FFF;
    localparam logic [13:0] MID_P_RETURN = 14'h0008;
    localparam logic [13:0] MID_P_RET_INT = 14'h0009;
    localparam logic [13:0] MID_P_CALL_W = 14'h000A;
    localparam logic [13:0] MID_P_BR_W = 14'h000B;
    localparam logic [13:0] MID_M_PTR_INC = 14'h3FF0;
    localparam logic [13:0] MID_P_PTR_INC = 14'h0010;
    localparam logic [13:0] MID_M_CLR_W = 14'h3FFC;
    localparam logic [13:0] MID_P_CLR_W = 14'h0100;
    localparam logic [13:0] MID_M_MOV_TO_F = 14'h3F80;
    localparam logic [13:0] MID_P_MOV_TO_F = 14'h0080;
    localparam logic [13:0] MID_M_BITSET = 14'h3800;
    localparam logic [13:0] MID_P_BITSET = 14'h1000;

    typedef enum logic [1:0] {
        MID_ST_EXEC,
        MID_ST_EXTRA,
        MID_ST_FLUSH
    } mid_state_type;

endpackage

// ===== design/mid_phase_gen.sv
/*
 * Free-running oscillator phase counter, four clocks per
 * instruction cycle. Assumes the core clock is the oscillator.
 */
`timescale 1ns/100ps

module mid_phase_gen
    import mid_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    output logic [1:0] phase_o,
    output logic last_o
);

    // ----------------------------------------------------------------
    // phase count
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            phase_o <= MID_PHASE_FIRST;
        else
            phase_o <= phase_o + 2'h1;
    end

    // registered so it lines up with the fourth phase
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            last_o <= 1'b0;
        else
            last_o <= (phase_o == MID_PHASE_PRELAST);
    end

endmodule

// ===== design/mid_decode_top.sv
/*
 * Instruction decode and cycle sequencer for an 8-bit core.
 * Assumes program memory presents the next fetched word on
 * instr_i by the last phase of every instruction cycle, and that
 * pointer targets arrive from logic on the same clock.
 */
// Function
// - one 14-bit word, no extension words
// - one instruction cycle unless exception applies
// - both call forms take two cycles
// - all three return forms take two cycles
// - jumps, branches and skips take two cycles
// - indirect access to program memory adds cycle
// - instruction cycle is four oscillator clocks
// - file operands are read, modified, stored
// - file read happens even for pure writes
// - file address spans 0x00 to 0x7F
// - destination bit zero to W, one to file
// - byte form: opcode, d, 7-bit file address
// - bit form: opcode, 3-bit position, address
// - literal form: opcode above 8-bit constant
// - pointer number picks pointer zero or one
// - don't-care bits never change decoding
// - call and jump carry 11-bit target
// - pointer increment carries number and 2-bit mode
`timescale 1ns/100ps

module mid_decode_top
    import mid_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [MID_INSTR_W-1:0] instr_i,
    input wire logic [1:0] ptr_in_prog_i,
    output logic [1:0] phase_o,
    output logic cycle_end_o,
    output logic [MID_INSTR_W-1:0] instr_o,
    output logic [MID_OPC_W-1:0] opcode_o,
    output logic dest_file_o,
    output logic [MID_F_W-1:0] file_addr_o,
    output logic [MID_B_W-1:0] bit_pos_o,
    output logic [MID_K8_W-1:0] literal_o,
    output logic [MID_K11_W-1:0] target_o,
    output logic ptr_num_o,
    output logic [MID_MM_W-1:0] ptr_mode_o,
    output logic two_cycle_o,
    output logic exec_o,
    output logic nop_o,
    output logic ind_stall_o,
    output logic discard_o,
    output logic file_rd_o,
    output logic file_wr_o,
    output logic w_wr_o
);

    // ----------------------------------------------------------------
    // opcode classes
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [13:0] w,
                                 input logic [13:0] m,
                                 input logic [13:0] p);
        hit = ((w & m) == p);
    endfunction

    function automatic logic f_two_cycle(input logic [13:0] w);
        f_two_cycle = hit(w, MID_M_TOP2, MID_P_ABS)
            || hit(w, MID_M_FULL, MID_P_CALL_W)
            || hit(w, MID_M_FULL, MID_P_RETURN)
            || hit(w, MID_M_FULL, MID_P_RET_INT)
            || hit(w, MID_M_OP6, MID_P_RET_LIT)
            || hit(w, MID_M_BRA, MID_P_BRA)
            || hit(w, MID_M_FULL, MID_P_BR_W)
            || hit(w, MID_M_BIT4, MID_P_SKIP_CLR)
            || hit(w, MID_M_BIT4, MID_P_SKIP_SET)
            || hit(w, MID_M_OP6, MID_P_DEC_SKIP)
            || hit(w, MID_M_OP6, MID_P_INC_SKIP);
    endfunction

    // byte forms with a d bit or an implicit store to f
    function automatic logic f_byte_op(input logic [13:0] w);
        logic [5:0] op;
        op = w[13:8];
        f_byte_op = 1'b0;
        if (op[5:4] == 2'h0)
            f_byte_op = (op[3:0] != 4'h0 || hit(w, MID_M_MOV_TO_F,
                MID_P_MOV_TO_F)) && !hit(w, MID_M_CLR_W,
                MID_P_CLR_W);
        else if (op[5:4] == 2'h3)
            f_byte_op = (op[3:0] == 4'h5) || (op[3:0] == 4'h6)
                || (op[3:0] == 4'h7) || (op[3:0] == 4'hB)
                || (op[3:0] == 4'hD);
    endfunction

    function automatic logic f_bit_op(input logic [13:0] w);
        f_bit_op = hit(w, MID_M_TOP2, MID_P_BITOP);
    endfunction

    function automatic logic f_ptr_inc(input logic [13:0] w);
        f_ptr_inc = hit(w, MID_M_PTR_INC, MID_P_PTR_INC);
    endfunction

    function automatic logic f_ptr_ofs(input logic [13:0] w);
        f_ptr_ofs = hit(w, MID_M_OP6, MID_P_PTR_OFS);
    endfunction

    // ----------------------------------------------------------------
    // phase timing
    // ----------------------------------------------------------------
    mid_phase_gen u_phase (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .phase_o(phase_o),
        .last_o(cycle_end_o)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    mid_state_type state;
    mid_state_type next_state;
    logic ind_hit;
    logic ind_ptr;
    logic penalty;
    logic load;

    assign penalty = ind_hit && ptr_in_prog_i[ind_ptr];
    assign load = cycle_end_o && (next_state == MID_ST_EXEC);

    always_comb
    begin
        case (state)
            MID_ST_EXEC:
            begin
                if (penalty)
                    next_state = MID_ST_EXTRA;
                else if (two_cycle_o)
                    next_state = MID_ST_FLUSH;
                else
                    next_state = MID_ST_EXEC;
            end
            MID_ST_EXTRA:
            begin
                if (two_cycle_o)
                    next_state = MID_ST_FLUSH;
                else
                    next_state = MID_ST_EXEC;
            end
            MID_ST_FLUSH:
                next_state = MID_ST_EXEC;
            default:
                next_state = MID_ST_FLUSH;
        endcase
    end

    // start in a flush cycle so the first word is fetched cleanly
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            state <= MID_ST_FLUSH;
        else if (cycle_end_o)
            state <= next_state;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            exec_o <= 1'b0;
            nop_o <= 1'b1;
            ind_stall_o <= 1'b0;
        end
        else if (cycle_end_o)
        begin
            exec_o <= (next_state == MID_ST_EXEC);
            nop_o <= (next_state == MID_ST_FLUSH);
            ind_stall_o <= (next_state == MID_ST_EXTRA);
        end
    end

    // word on instr_i while entering a flush is the stale prefetch
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            discard_o <= 1'b0;
        else
            discard_o <= cycle_end_o
                && (next_state == MID_ST_FLUSH);
    end

    // ----------------------------------------------------------------
    // field capture, whole word at once
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            instr_o <= '0;
            opcode_o <= '0;
            dest_file_o <= 1'b0;
            file_addr_o <= '0;
            bit_pos_o <= '0;
            literal_o <= '0;
            target_o <= '0;
            ptr_num_o <= 1'b0;
            ptr_mode_o <= '0;
            two_cycle_o <= 1'b0;
        end
        else if (load)
        begin
            instr_o <= instr_i;
            opcode_o <= instr_i[MID_OPC_LSB +: MID_OPC_W];
            dest_file_o <= instr_i[MID_D_BIT];
            file_addr_o <= instr_i[MID_F_W-1:0] & MID_F_MAX;
            bit_pos_o <= instr_i[MID_B_LSB +: MID_B_W];
            literal_o <= instr_i[MID_K8_W-1:0];
            target_o <= instr_i[MID_K11_W-1:0];
            if (f_ptr_inc(instr_i))
                ptr_num_o <= instr_i[MID_N_INC_BIT];
            else
                ptr_num_o <= instr_i[MID_N_OFS_BIT];
            ptr_mode_o <= instr_i[MID_MM_W-1:0];
            two_cycle_o <= f_two_cycle(instr_i);
        end
    end

    // indirect reach: the two lowest file addresses or pointer forms
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            ind_hit <= 1'b0;
            ind_ptr <= 1'b0;
        end
        else if (load)
        begin
            if (f_ptr_inc(instr_i))
            begin
                ind_hit <= 1'b1;
                ind_ptr <= instr_i[MID_N_INC_BIT];
            end
            else if (f_ptr_ofs(instr_i))
            begin
                ind_hit <= 1'b1;
                ind_ptr <= instr_i[MID_N_OFS_BIT];
            end
            else
            begin
                ind_hit <= (f_byte_op(instr_i) || f_bit_op(instr_i))
                    && (instr_i[6:1] == MID_INDIRECT_FILE_REGISTER_HI);
                ind_ptr <= instr_i[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read-modify-write strobes, held for the execute cycle
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            file_rd_o <= 1'b0;
            file_wr_o <= 1'b0;
            w_wr_o <= 1'b0;
        end
        else if (load)
        begin
            // read even for store-only forms, side effects must fire
            file_rd_o <= f_byte_op(instr_i) || f_bit_op(instr_i);
            file_wr_o <= (f_byte_op(instr_i) && instr_i[MID_D_BIT])
                || hit(instr_i, MID_M_BITSET, MID_P_BITSET);
            w_wr_o <= f_byte_op(instr_i)
                && !instr_i[MID_D_BIT];
        end
        else if (cycle_end_o)
        begin
            file_rd_o <= 1'b0;
            file_wr_o <= 1'b0;
            w_wr_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    phase_wrap_a: assert property (
        phase_o == 2'h3 |=> phase_o == MID_PHASE_FIRST)
        else $error("phase did not wrap to first");

    four_clock_a: assert property (
        cycle_end_o |=> !cycle_end_o [*3] ##1 cycle_end_o)
        else $error("instruction cycle not four clocks");

    end_phase_a: assert property (
        cycle_end_o == (phase_o == 2'h3))
        else $error("cycle end off the last phase");

    single_cycle_a: assert property (
        cycle_end_o && exec_o && !two_cycle_o && !penalty
        |=> exec_o [*4])
        else $error("single cycle word did not advance");

    two_cycle_nop_a: assert property (
        cycle_end_o && exec_o && two_cycle_o && !penalty
        |=> nop_o && discard_o ##1 nop_o [*3] ##1 exec_o)
        else $error("second cycle not a flush");

    ind_penalty_a: assert property (
        cycle_end_o && exec_o && penalty
        |=> ind_stall_o [*4] ##1 !ind_stall_o)
        else $error("indirect penalty cycle missing");

    rmw_read_a: assert property (
        file_wr_o |-> file_rd_o && exec_o)
        else $error("file store without read");

    dest_route_a: assert property (
        w_wr_o |-> !dest_file_o && !file_wr_o)
        else $error("result routed to both places");

    field_load_a: assert property (
        load |=> file_addr_o == $past(instr_i[6:0])
        && dest_file_o == $past(instr_i[7]))
        else $error("file fields not captured");

    literal_load_a: assert property (
        load |=> literal_o == $past(instr_i[7:0])
        && target_o == $past(instr_i[10:0]))
        else $error("literal fields not captured");

    single_cov: cover property (
        cycle_end_o && exec_o && !two_cycle_o ##1 exec_o);
    two_cycle_cov: cover property (
        cycle_end_o && exec_o && two_cycle_o ##1 nop_o);
    penalty_cov: cover property (
        cycle_end_o && exec_o && penalty ##1 ind_stall_o);
    both_cov: cover property (
        ind_stall_o && two_cycle_o && cycle_end_o ##1 nop_o);

endmodule

// ===== tb/mid_prog_mem.sv
/*
 * Program memory model that hands fetched words to the decoder.
 * Assumes the bench loads words in program order, at most one a
 * clock, and that a word counts as taken once its execute cycle
 * shows up at phase zero.
 */
`timescale 1ns/100ps

module mid_prog_mem
    import mid_pkg::*;
(
    input wire logic mclk_i,
    input wire logic load_i,
    input wire logic [MID_INSTR_W-1:0] load_word_i,
    input wire logic exec_i,
    input wire logic [1:0] phase_i,
    input wire logic two_cycle_i,
    input wire logic nop_i,
    output logic [MID_INSTR_W-1:0] instr_o
);
    logic [MID_INSTR_W-1:0] words[$];
    logic [MID_INSTR_W-1:0] head = 14'h0000;

    always @(posedge mclk_i)
    begin
        if (load_i === 1'b1)
            words.push_back(load_word_i);
        // one whole word per instruction, never an extension word
        if (exec_i === 1'b1 && phase_i === 2'h0 && words.size() > 0)
            void'(words.pop_front());
        head <= (words.size() > 0) ? words[0] : 14'h0000;
    end

    // junk while a two-cycle word runs: any prefetch taken there is wrong
    assign instr_o = (two_cycle_i === 1'b1 && nop_i !== 1'b1) ?
                     ~head : head;
endmodule

// ===== tb/mcu_instruction_decode_timing_tb.sv
/*
 * Self-checking bench for the instruction decoder and sequencer.
 * Assumes the design package and the program memory model.
 */
`timescale 1ns/100ps

module mcu_instruction_decode_timing_tb
    import mid_pkg::*;
;
    localparam int NW = 140;
    localparam int NC = 21;
    localparam int NK = 10;
    localparam logic [13:0] BASE [NC] = '{14'h0700, 14'h0080, 14'h0180,
        14'h1000, 14'h1400, 14'h1800, 14'h1C00, 14'h0B00, 14'h0F00,
        14'h2000, 14'h2800, 14'h3000, 14'h3400, 14'h3200, 14'h0008,
        14'h0009, 14'h000A, 14'h000B, 14'h0100, 14'h0010, 14'h0000};
    localparam logic [13:0] MASK [NC] = '{14'h00FF, 14'h007F, 14'h007F,
        14'h03FF, 14'h03FF, 14'h03FF, 14'h03FF, 14'h00FF, 14'h00FF,
        14'h07FF, 14'h07FF, 14'h00FF, 14'h00FF, 14'h01FF, 14'h0000,
        14'h0000, 14'h0000, 14'h0000, 14'h0003, 14'h000F, 14'h0000};
    // 1 byte file op, 2 bit write, 3 bit test, 4 and 5 strobes unchecked
    localparam int FOP [NC] = '{1, 1, 1, 2, 2, 3, 3, 1, 1, 0, 0, 0, 0,
        0, 0, 0, 0, 0, 4, 5, 0};
    localparam int TWO [NC] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 0, 1,
        1, 1, 1, 1, 1, 0, 0, 0};
    localparam int KC [NK] = '{1, 1, 5, 19, 19, 14, 17, 9, 18, 0};
    localparam int KF [NK] = '{0, 127, 1, 3, 6, 0, 0, 2047, 3, 1};
    localparam logic [1:0] KP [NK] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h1,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0};

    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic load = 1'b0;
    logic [13:0] load_word = 14'h0000;
    logic [13:0] instr_i;
    logic [1:0] ptr_in_prog_i;
    logic [1:0] phase_o;
    logic cycle_end_o, dest_file_o, ptr_num_o, two_cycle_o, exec_o;
    logic nop_o, ind_stall_o, discard_o, file_rd_o, file_wr_o, w_wr_o;
    logic [13:0] instr_o;
    logic [5:0] opcode_o;
    logic [6:0] file_addr_o;
    logic [2:0] bit_pos_o;
    logic [7:0] literal_o;
    logic [10:0] target_o;
    logic [1:0] ptr_mode_o;
    logic [13:0] wv [NW];
    logic [1:0] pv [NW];
    int cv [NW];
    int errors = 0;
    int check_count = 0;
    int k = 0;
    int rst_n = 0;
    int n_clk, n_stall, n_nop, n_disc;
    logic ppen, ptwo, pok, run_on;
    logic [1:0] last_phase, want_phase;

    always #2 mclk_i = ~mclk_i;

    mid_decode_top i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .instr_i(instr_i), .ptr_in_prog_i(ptr_in_prog_i),
        .phase_o(phase_o), .cycle_end_o(cycle_end_o), .instr_o(instr_o),
        .opcode_o(opcode_o), .dest_file_o(dest_file_o),
        .file_addr_o(file_addr_o), .bit_pos_o(bit_pos_o),
        .literal_o(literal_o), .target_o(target_o),
        .ptr_num_o(ptr_num_o), .ptr_mode_o(ptr_mode_o),
        .two_cycle_o(two_cycle_o), .exec_o(exec_o), .nop_o(nop_o),
        .ind_stall_o(ind_stall_o), .discard_o(discard_o),
        .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .w_wr_o(w_wr_o));

    mid_prog_mem i_mem (.mclk_i(mclk_i), .load_i(load),
        .load_word_i(load_word), .exec_i(exec_o), .phase_i(phase_o),
        .two_cycle_i(two_cycle_o), .nop_i(nop_o), .instr_o(instr_i));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic pen_of(input int c, input logic [13:0] w,
                                    input logic [1:0] p);
        if (FOP[c] == 5)
            return p[w[2]];
        if (FOP[c] >= 1 && FOP[c] <= 3 && w[6:1] == 6'h00)
            return p[w[0]];
        return 1'b0;
    endfunction

    task automatic check_word(input logic [13:0] w, input int c,
                              input logic [1:0] p);
        logic [2:0] s;
        ppen = pen_of(c, w, p);
        ptwo = (TWO[c] != 0);
        case (FOP[c])
            1: s = {1'b1, w[7], ~w[7]};
            2: s = 3'b110;
            3: s = 3'b100;
            default: s = 3'b000;
        endcase
        check(32'(instr_o), 32'(w));
        check(32'(opcode_o), 32'(w[13:8]));
        check(32'(dest_file_o), 32'(w[7]));
        check(32'(file_addr_o), 32'(w[6:0]));
        check(32'(bit_pos_o), 32'(w[9:7]));
        check(32'(literal_o), 32'(w[7:0]));
        check(32'(target_o), 32'(w[10:0]));
        check(32'(ptr_mode_o), 32'(w[1:0]));
        check(32'(ptr_num_o), 32'(FOP[c] == 5 ? w[2] : w[6]));
        check(32'(two_cycle_o), 32'(ptwo));
        check(32'({nop_o, ind_stall_o}), 32'h0);
        if (FOP[c] < 4)
            check(32'({file_rd_o, file_wr_o, w_wr_o}), 32'(s));
    endtask

    task automatic complete_run();
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor, sampled mid-clock where outputs are settled
    // ------------------------------------------------------------
    always @(negedge mclk_i)
    begin
        if (rstn_i !== 1'b1)
        begin
            rst_n++;
            run_on = 1'b0;
            pok = 1'b0;
            if (rst_n > 2)
                check(32'({phase_o, cycle_end_o, exec_o, nop_o}),
                    32'h1);
        end
        else
        begin
            want_phase = last_phase + 2'h1;
            if (run_on)
                check(32'(phase_o), 32'(want_phase));
            check(32'(cycle_end_o), 32'(phase_o == 2'h3));
            last_phase = phase_o;
            run_on = 1'b1;
            if (exec_o === 1'b1 && phase_o === 2'h0)
            begin
                if (pok)
                begin
                    check(32'(n_clk), 32'(4 * (1 + ppen + ptwo)));
                    check(32'(n_stall), 32'(4 * ppen));
                    check(32'(n_nop), 32'(4 * ptwo));
                    check(32'(n_disc), 32'(ptwo));
                end
                pok = (k < NW);
                if (pok)
                    check_word(wv[k], cv[k], pv[k]);
                k++;
                n_clk = 0;
                n_stall = 0;
                n_nop = 0;
                n_disc = 0;
            end
            n_clk++;
            n_stall += ind_stall_o;
            n_nop += nop_o;
            n_disc += discard_o;
        end
    end

    // executing word's targets stand until its cycle-end sample
    always @(posedge mclk_i)
        if (rstn_i === 1'b1 && exec_o === 1'b1 && phase_o === 2'h0)
            ptr_in_prog_i <= (k >= 1 && k <= NW) ? pv[k - 1] : 2'h0;

    initial
    begin
        void'($urandom(80));
        for (int i = 0; i < NW; i++)
        begin
            cv[i] = (i < NK) ? KC[i] : int'($urandom % NC);
            wv[i] = BASE[cv[i]] |
                    (14'((i < NK) ? KF[i] : $urandom) & MASK[cv[i]]);
            pv[i] = (i < NK) ? KP[i] : 2'($urandom);
        end
        ptr_in_prog_i = pv[0];
        for (int i = 0; i < NW; i++)
        begin
            @(posedge mclk_i);
            load <= 1'b1;
            load_word <= wv[i];
            if (i == 9)
                rstn_i <= 1'b1;
        end
        @(posedge mclk_i);
        load <= 1'b0;
        for (int t = 0; t < 20 * NW && k <= NW; t++)
            @(posedge mclk_i);
        if (k <= NW)
            errors++;
        complete_run();
    end

    // stalls are cut short long after the slowest possible program
    initial
    begin
        #(4 * 24 * NW);
        errors++;
        complete_run();
    end
endmodule
